/* verilog/irqsr_regs.vh */
// ----------------------------------------
// register map and timing of the sync block
// ----------------------------------------
`ifndef IRQSR_REGS_VH
`define IRQSR_REGS_VH

// byte offsets, index times four (printed offsets are not word aligned)
`define IRQSR_IDX_PIN_SEL 8'h2B
`define IRQSR_IDX_SUMMARY 8'h2C
`define IRQSR_IDX_SKIP 8'h36
`define IRQSR_IDX_JITTER 8'h39
`define IRQSR_IDX_MODE 8'h3A
`define IRQSR_IDX_ROT 8'h3B
`define IRQSR_ADDR_PIN_SEL 12'h0AC
`define IRQSR_ADDR_SUMMARY 12'h0B0
`define IRQSR_ADDR_SKIP 12'h0D8
`define IRQSR_ADDR_JITTER 12'h0E4
`define IRQSR_ADDR_MODE 12'h0E8
`define IRQSR_ADDR_ROT 12'h0EC
// own registers: latched events and enables
`define IRQSR_ADDR_EVT_STAT 12'h100
`define IRQSR_ADDR_EVT_EN 12'h104

// field positions
`define IRQSR_BIT_PLL_LOCK 0
`define IRQSR_BIT_PLL_LOST 1
`define IRQSR_BIT_DLL_LOCK 4
`define IRQSR_BIT_DLL_LOST 5
`define IRQSR_BIT_ONESHOT 1
`define IRQSR_BIT_ROT_DONE 4
`define IRQSR_BIT_OSC_RST 4
`define IRQSR_BIT_PERIODIC 5
`define IRQSR_BIT_RSVD6 6
`define IRQSR_BIT_SYNC_EN 7

// reset values
`define IRQSR_RST_PIN_SEL 6'h00
`define IRQSR_RST_SKIP 8'h00
`define IRQSR_RST_JITTER 7'h00
`define IRQSR_RST_ROT 8'hB0
`define IRQSR_RST_ROT_DONE 1'h1

// soft ramp hold count in pclk cycles
`define IRQSR_RAMP_CYCLES 4'h8

`endif

/* verilog/irqsr_edge_meas.v */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// timing pulse edge detector and period meter
// ----------------------------------------
module irqsr_edge_meas (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // timing pulse input
  input wire sysref_in,
  // measurement
  output wire edge_pulse,
  output reg [15:0] period_r,
  output reg period_valid_r
);
  reg sysref_d_r; // previous level
  reg [15:0] cnt_r; // cycles since last edge
  reg seen_r; // one edge already seen

  assign edge_pulse = sysref_in & ~sysref_d_r;

  // count cycles between rising edges; first edge has no period yet
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_d_r <= 1'b0;
      cnt_r <= 16'h0000;
      seen_r <= 1'b0;
      period_r <= 16'h0000;
      period_valid_r <= 1'b0;
    end else begin
      sysref_d_r <= sysref_in;
      period_valid_r <= 1'b0;
      if (edge_pulse) begin
        // period includes the edge cycle itself
        period_r <= cnt_r + 16'h0001;
        period_valid_r <= seen_r;
        seen_r <= 1'b1;
        cnt_r <= 16'h0000;
      end else if (cnt_r != 16'hFFFF) begin
        // saturate the count; an edge after saturation still reports period 0
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule // irqsr_edge_meas
`default_nettype wire

/* verilog/irqsr_pin_route.v */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// steer latched events to the two pins
// ----------------------------------------
module irqsr_pin_route (
  // latched, enabled events
  input wire [3:0] evt_active,
  // pin select per event, 0 = pin a
  input wire [3:0] pin_sel,
  // pins
  output reg pin_a,
  output reg pin_b
);
  integer i;

  // each event feeds exactly one pin
  always @* begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (evt_active[i] && !pin_sel[i]) pin_a = 1'b1;
      if (evt_active[i] && pin_sel[i]) pin_b = 1'b1;
    end
  end
endmodule // irqsr_pin_route
`default_nettype wire

/* verilog/irqsr_sync_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "irqsr_regs.vh"

// Behaviour
// - delay unlock event routed by select bit 5
// - delay locked event routed by select bit 4
// - phase unlock event routed by select bit 1
// - phase locked routed by bit 0, default pin a
// - summary bit is OR of latched loop events
// - writing one to summary clears all latched loop events, not the jitter flag
// - ignore counted timing edges before syncing
// - jitter above tolerance raises an interrupt
// - monitor mode flags edges outside window
// - one-shot aligns on the first edge after the skipped ones, then monitors
// - rotation done flag, reads one after reset
// - rotation resets links and/or ramps datapath
// - optional oscillator reset after rotation or reset
module irqsr_sync_ctrl (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // loop lock events, one-cycle pulses
  input wire pll_lock_evt,
  input wire pll_lost_evt,
  input wire dll_lock_evt,
  input wire dll_lost_evt,
  // timing pulse from the clock generator
  input wire sysref_in,
  // interrupt pins
  output wire interrupt_pin_a,
  output wire interrupt_pin_b,
  // rotation actions
  output reg link_clk_reset_r,
  output reg datapath_ramp_off_r,
  output reg osc_reset_r,
  // interrupt from jitter status, gated by its mask
  output wire irq
);
  // ----------------------------------------
  // states of the alignment sequencer
  // ----------------------------------------
  localparam [3:0] ST_MON = 4'b0001; // monitoring only
  localparam [3:0] ST_SKIP = 4'b0010; // one-shot armed, counting edges
  localparam [3:0] ST_ROT = 4'b0100; // rotation in progress
  localparam [3:0] ST_POST = 4'b1000; // finishing up

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [5:0] pin_sel_r; // bits 5,4,1,0 used; 3:2 plain storage
  reg [7:0] skip_count_r; // pulse_skip_count
  reg [6:0] jitter_tol_r; // pulse_jitter_tolerance
  reg single_align_enable_r; // one-shot arm bit
  reg mode_rsvd0_r; // reserved r/w bit 0
  reg rot_done_r; // rotation complete
  reg [7:0] rot_ctrl_r; // align_rotation_control
  reg [3:0] evt_stat_r; // latched loop events
  reg [3:0] evt_en_r; // event enables
  reg jitter_stat_r; // pulse_jitter_event sticky
  reg jitter_mask_r; // mask for irq
  reg [3:0] state_r; // sequencer state
  reg [7:0] skip_left_r; // edges still to ignore
  reg [3:0] ramp_cnt_r; // action hold counter
  reg reset_seen_r; // one cycle after reset release

  // edge measurement
  wire edge_pulse;
  wire [15:0] period;
  wire period_valid;
  reg [15:0] ref_period_r; // reference edge spacing
  reg ref_valid_r;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // writes land at the access edge only; the setup cycle changes only prdata, on reads
  wire wr_en = psel & penable & pwrite;
  wire [3:0] evt_in = {dll_lost_evt, dll_lock_evt, pll_lost_evt, pll_lock_evt};
  wire [3:0] pin_sel4 = {pin_sel_r[`IRQSR_BIT_DLL_LOST], pin_sel_r[`IRQSR_BIT_DLL_LOCK],
                         pin_sel_r[`IRQSR_BIT_PLL_LOST], pin_sel_r[`IRQSR_BIT_PLL_LOCK]};
  wire summary = |evt_stat_r;

  // decode used by write and read paths
  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a[11:2] == b[11:2]);
    end
  endfunction

  wire clr_all = wr_en & is_addr(paddr, `IRQSR_ADDR_SUMMARY) & pwdata[0];
  wire mapped = is_addr(paddr, `IRQSR_ADDR_PIN_SEL) | is_addr(paddr, `IRQSR_ADDR_SUMMARY) |
                is_addr(paddr, `IRQSR_ADDR_SKIP) | is_addr(paddr, `IRQSR_ADDR_JITTER) |
                is_addr(paddr, `IRQSR_ADDR_MODE) | is_addr(paddr, `IRQSR_ADDR_ROT) |
                is_addr(paddr, `IRQSR_ADDR_EVT_STAT) | is_addr(paddr, `IRQSR_ADDR_EVT_EN);

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // the error rides the access phase, so the master sees it together with pready

  // jitter: deviation of this spacing from the reference
  // absolute difference; after a saturated count the period wraps to 0
  wire [15:0] dev = (period > ref_period_r) ? (period - ref_period_r) : (ref_period_r - period);
  wire jitter_hit = period_valid & ref_valid_r & (dev > {9'h000, jitter_tol_r});

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sel_r <= `IRQSR_RST_PIN_SEL; // pin a after reset
      skip_count_r <= `IRQSR_RST_SKIP;
      jitter_tol_r <= `IRQSR_RST_JITTER;
      mode_rsvd0_r <= 1'b0;
      rot_ctrl_r <= `IRQSR_RST_ROT;
      evt_en_r <= 4'h0;
      jitter_mask_r <= 1'b0;
    end else if (wr_en) begin
      if (is_addr(paddr, `IRQSR_ADDR_PIN_SEL)) pin_sel_r <= pwdata[5:0];
      if (is_addr(paddr, `IRQSR_ADDR_SKIP)) skip_count_r <= pwdata[7:0];
      if (is_addr(paddr, `IRQSR_ADDR_JITTER)) jitter_tol_r <= pwdata[6:0];
      if (is_addr(paddr, `IRQSR_ADDR_MODE)) mode_rsvd0_r <= pwdata[0];
      // bits 3:2 reserved read-only zero; software sets 7:4 and 1:0
      if (is_addr(paddr, `IRQSR_ADDR_ROT)) rot_ctrl_r <= {pwdata[7:4], 2'b00, pwdata[1:0]};
      if (is_addr(paddr, `IRQSR_ADDR_EVT_EN)) begin
        evt_en_r <= pwdata[3:0];
        jitter_mask_r <= pwdata[8];
      end
    end
  end

  // ----------------------------------------
  // latched events, set wins over clear
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_r <= 4'h0;
      jitter_stat_r <= 1'b0;
    end else begin
      // summary write one clears all, own write-one-clear per bit too
      // an event arriving in the clearing cycle survives, so none is lost
      if (clr_all) evt_stat_r <= evt_in & evt_en_r;
      else if (wr_en && is_addr(paddr, `IRQSR_ADDR_EVT_STAT))
        evt_stat_r <= (evt_stat_r & ~pwdata[3:0]) | (evt_in & evt_en_r);
      else
        evt_stat_r <= evt_stat_r | (evt_in & evt_en_r);
      // jitter flag only in monitor mode
      if (jitter_hit && state_r == ST_MON) jitter_stat_r <= 1'b1;
      else if (wr_en && is_addr(paddr, `IRQSR_ADDR_EVT_STAT) && pwdata[8]) jitter_stat_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // reference edge spacing
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_period_r <= 16'h0000;
      ref_valid_r <= 1'b0;
    end else if (period_valid && !ref_valid_r) begin
      // first full period becomes the reference
      // never refreshed: a deliberate rate change reads as jitter until reset
      ref_period_r <= period;
      ref_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // alignment sequencer
  // ----------------------------------------
  // arming is ignored while the align logic enable is clear
  wire arm = wr_en & is_addr(paddr, `IRQSR_ADDR_MODE) & pwdata[`IRQSR_BIT_ONESHOT];
  wire sync_en = rot_ctrl_r[`IRQSR_BIT_SYNC_EN];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_MON;
      single_align_enable_r <= 1'b0;
      rot_done_r <= `IRQSR_RST_ROT_DONE;
      skip_left_r <= 8'h00;
      ramp_cnt_r <= 4'h0;
      link_clk_reset_r <= 1'b0;
      datapath_ramp_off_r <= 1'b0;
      osc_reset_r <= 1'b0;
      reset_seen_r <= 1'b0;
    end else begin
      reset_seen_r <= 1'b1;
      osc_reset_r <= 1'b0;
      // oscillators reset once after a digital reset
      if (!reset_seen_r && rot_ctrl_r[`IRQSR_BIT_OSC_RST]) osc_reset_r <= 1'b1;
      case (state_r)
        ST_MON: begin
          if (arm && sync_en) begin
            // armed: drop done flag and load the skip count
            state_r <= ST_SKIP;
            single_align_enable_r <= 1'b1;
            rot_done_r <= 1'b0;
            skip_left_r <= skip_count_r;
          end
        end
        ST_SKIP: begin
          if (edge_pulse) begin
            // a skip count of zero rotates on the very first edge after arming
            if (skip_left_r != 8'h00) begin
              skip_left_r <= skip_left_r - 8'h01; // ignore this edge
            end else begin
              // rotate on this edge with the selected actions
              state_r <= ST_ROT;
              link_clk_reset_r <= rot_ctrl_r[0];
              datapath_ramp_off_r <= rot_ctrl_r[1];
              ramp_cnt_r <= `IRQSR_RAMP_CYCLES;
            end
          end
        end
        ST_ROT: begin
          // hold the actions for a fixed time, then release them
          // the fixed hold gives the lanes time to settle before links restart
          if (ramp_cnt_r != 4'h0) begin
            ramp_cnt_r <= ramp_cnt_r - 4'h1;
          end else begin
            link_clk_reset_r <= 1'b0;
            datapath_ramp_off_r <= 1'b0;
            state_r <= ST_POST;
          end
        end
        ST_POST: begin
          // done, back to monitor by itself
          rot_done_r <= 1'b1;
          single_align_enable_r <= 1'b0;
          if (rot_ctrl_r[`IRQSR_BIT_OSC_RST]) osc_reset_r <= 1'b1;
          state_r <= ST_MON;
        end
        default: begin
          state_r <= ST_MON;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux, registered data
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      // sampled in the setup cycle, valid for the access edge
      // unmapped addresses and unused bits read as zero; reserved mode bit 0 and rotation bit 6 read back
      prdata <= 32'h00000000;
      if (is_addr(paddr, `IRQSR_ADDR_PIN_SEL)) prdata <= {26'h0000000, pin_sel_r};
      if (is_addr(paddr, `IRQSR_ADDR_SUMMARY)) prdata <= {31'h00000000, summary};
      if (is_addr(paddr, `IRQSR_ADDR_SKIP)) prdata <= {24'h000000, skip_count_r};
      if (is_addr(paddr, `IRQSR_ADDR_JITTER)) prdata <= {25'h0000000, jitter_tol_r};
      if (is_addr(paddr, `IRQSR_ADDR_MODE))
        prdata <= {27'h0000000, rot_done_r, 2'b00, single_align_enable_r, mode_rsvd0_r};
      if (is_addr(paddr, `IRQSR_ADDR_ROT)) prdata <= {24'h000000, rot_ctrl_r};
      if (is_addr(paddr, `IRQSR_ADDR_EVT_STAT)) prdata <= {23'h000000, jitter_stat_r, 4'h0, evt_stat_r};
      if (is_addr(paddr, `IRQSR_ADDR_EVT_EN)) prdata <= {23'h000000, jitter_mask_r, 4'h0, evt_en_r};
    end
  end

  // level output; stays high until software clears the jitter status bit or its mask bit
  assign irq = jitter_stat_r & jitter_mask_r;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  irqsr_edge_meas u_meas (
    .pclk(pclk),
    .presetn(presetn),
    .sysref_in(sysref_in),
    .edge_pulse(edge_pulse),
    .period_r(period),
    .period_valid_r(period_valid)
  );

  // pins follow latched events and selects
  irqsr_pin_route u_route (
    .evt_active(evt_stat_r & evt_en_r),
    .pin_sel(pin_sel4),
    .pin_a(interrupt_pin_a),
    .pin_b(interrupt_pin_b)
  );
endmodule // irqsr_sync_ctrl
`default_nettype wire

/* sim/irqsr_sync_ctrl_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "irqsr_regs.vh"
// ----------------------------------------
// port checker of the sync block
// ----------------------------------------
module irqsr_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // loop events
  input wire logic pll_lock_evt,
  input wire logic pll_lost_evt,
  input wire logic dll_lock_evt,
  input wire logic dll_lost_evt,
  // outputs
  input wire logic interrupt_pin_a,
  input wire logic interrupt_pin_b,
  input wire logic link_clk_reset_r,
  input wire logic datapath_ramp_off_r,
  input wire logic osc_reset_r
);
  logic [3:0] en_r; // shadow of loop event enables
  logic [3:0] sel_r; // shadow of pin selects
  logic osc_en_r; // shadow of oscillator reset enable
  wire wr = psel && penable && pwrite; // write takes effect here
  wire evts = pll_lock_evt | pll_lost_evt | dll_lock_evt | dll_lost_evt;
  // ----------------------------------------
  // shadows follow host writes at the access edge
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 4'h0;
      sel_r <= 4'h0;
      osc_en_r <= 1'b1;
    end else if (wr && paddr == `IRQSR_ADDR_EVT_EN) begin
      en_r <= pwdata[3:0];
    end else if (wr && paddr == `IRQSR_ADDR_PIN_SEL) begin
      sel_r <= {pwdata[5:4], pwdata[1:0]};
    end else if (wr && paddr == `IRQSR_ADDR_ROT) begin
      osc_en_r <= pwdata[4];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // action held nine cycles, then dropped
  sequence span_s(x);
    x[*8] ##1 x ##1 !x;
  endsequence
  // a taken event shows on the selected pin next cycle
  property route_p(e, en, s);
    e && en && !wr |=> (s ? interrupt_pin_b : interrupt_pin_a);
  endproperty
  pll_lock_route_a:
    assert property (route_p(pll_lock_evt, en_r[0], sel_r[0])) else $error("pll lock pin");
  pll_lost_route_a:
    assert property (route_p(pll_lost_evt, en_r[1], sel_r[1])) else $error("pll lost pin");
  dll_lock_route_a:
    assert property (route_p(dll_lock_evt, en_r[2], sel_r[2])) else $error("dll lock pin");
  dll_lost_route_a:
    assert property (route_p(dll_lost_evt, en_r[3], sel_r[3])) else $error("dll lost pin");
  summary_clear_a:
    assert property (wr && paddr == `IRQSR_ADDR_SUMMARY && pwdata[0] && !evts
      |=> !interrupt_pin_a && !interrupt_pin_b) else $error("pins after clear");
  link_span_a:
    assert property ($rose(link_clk_reset_r) |-> span_s(link_clk_reset_r))
      else $error("link reset length");
  ramp_span_a:
    assert property ($rose(datapath_ramp_off_r) |-> span_s(datapath_ramp_off_r))
      else $error("ramp length");
  osc_single_a:
    assert property (osc_reset_r |=> !osc_reset_r) else $error("osc pulse too long");
  osc_after_rot_a:
    assert property ($fell(link_clk_reset_r) && osc_en_r |-> ##[0:2] osc_reset_r)
      else $error("no osc reset");
  unmapped_err_a:
    assert property (psel && penable && paddr[11:9] != 3'h0 |-> pslverr)
      else $error("no slave error");
endmodule // irqsr_chk

bind irqsr_sync_ctrl irqsr_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .pll_lock_evt(pll_lock_evt), .pll_lost_evt(pll_lost_evt), .dll_lock_evt(dll_lock_evt),
  .dll_lost_evt(dll_lost_evt), .interrupt_pin_a(interrupt_pin_a),
  .interrupt_pin_b(interrupt_pin_b), .link_clk_reset_r(link_clk_reset_r),
  .datapath_ramp_off_r(datapath_ramp_off_r), .osc_reset_r(osc_reset_r));
`default_nettype wire

/* sim/irqsr_pulse_gen.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// clock generator model: timing pulse source
// ----------------------------------------
module irqsr_pulse_gen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [7:0] period,
  // timing pulse
  output logic sysref
);
  logic [7:0] cnt_r; // cycles since the last rise
  // two-cycle pulse every period cycles; a longer period changes the current gap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      sysref <= 1'b0;
    end else begin
      sysref <= run && (cnt_r < 8'h02);
      if (!run || cnt_r >= period - 8'h01) begin
        cnt_r <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // irqsr_pulse_gen
`default_nettype wire

/* sim/irqsr_sync_ctrl_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "irqsr_regs.vh"
// ----------------------------------------
// register level bench of the sync block
// ----------------------------------------
module irqsr_sync_ctrl_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] evt = 4'h0; // {dll_lost, dll_lock, pll_lost, pll_lock}
  logic run = 1'b0;
  logic [7:0] period = 8'h14;
  wire sysref, pready, pslverr, pin_a, pin_b, lnk, ramp, osc, irq;
  wire [31:0] prdata;
  logic [31:0] rd; // read data of the last transfer
  logic err; // slave error of the last transfer
  int n_errors = 0;
  int tests_run = 0;
  int n_edges = 0;
  int i;
  int s;
  int k;
  always #25 pclk = ~pclk;
  always @(posedge sysref) n_edges++;
  irqsr_pulse_gen gen_u (.pclk(pclk), .presetn(presetn), .run(run), .period(period),
    .sysref(sysref));
  irqsr_sync_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pll_lock_evt(evt[0]), .pll_lost_evt(evt[1]), .dll_lock_evt(evt[2]),
    .dll_lost_evt(evt[3]), .sysref_in(sysref), .interrupt_pin_a(pin_a),
    .interrupt_pin_b(pin_b), .link_clk_reset_r(lnk), .datapath_ramp_off_r(ramp),
    .osc_reset_r(osc), .irq(irq));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one apb transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait for the rotation to start, bounded
  task automatic wait_rot();
    k = 0;
    while (lnk !== 1'b1 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 500) begin
      n_errors++;
      conclude();
    end
  endtask
  initial begin
    #1000000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    @(negedge pclk);
    check(osc, 1'b1);
    apb(0, `IRQSR_ADDR_ROT, 0);
    check(rd, 32'hB0);
    apb(0, `IRQSR_ADDR_MODE, 0);
    check(rd, 32'h10);
    apb(0, `IRQSR_ADDR_PIN_SEL, 0);
    check(rd, 32'h0);
    apb(0, 12'h200, 0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1, `IRQSR_ADDR_EVT_EN, 32'h0F);
    // every loop event on both pins, cleared by the summary bit
    for (s = 0; s < 2; s++) begin
      for (i = 0; i < 4; i++) begin
        apb(1, `IRQSR_ADDR_PIN_SEL, s ? 32'h33 : 32'h0);
        @(posedge pclk);
        evt[i] <= 1'b1;
        @(posedge pclk);
        evt[i] <= 1'b0;
        @(posedge pclk);
        check({pin_b, pin_a}, s ? 2'b10 : 2'b01);
        apb(0, `IRQSR_ADDR_SUMMARY, 0);
        check(rd, 32'h1);
        apb(1, `IRQSR_ADDR_SUMMARY, 32'h1);
        apb(0, `IRQSR_ADDR_EVT_STAT, 0);
        check(rd[3:0], 4'h0);
        check({pin_b, pin_a}, 2'b00);
      end
    end
    // one-shot after two skipped edges, both actions
    apb(1, `IRQSR_ADDR_ROT, 32'hF3);
    apb(1, `IRQSR_ADDR_SKIP, 32'h02);
    apb(1, `IRQSR_ADDR_MODE, 32'h02);
    apb(0, `IRQSR_ADDR_MODE, 0);
    check(rd[4], 1'b0);
    n_edges = 0;
    run <= 1'b1;
    wait_rot();
    check(n_edges, 3);
    check(ramp, 1'b1);
    // exactly one oscillator reset pulse follows the rotation
    s = 0;
    repeat (12) begin
      @(negedge pclk);
      if (osc === 1'b1) s++;
    end
    check(s, 1);
    apb(0, `IRQSR_ADDR_MODE, 0);
    check(rd, 32'h10);
    // jitter: 2 off tolerated, 3 off flagged, mask gates irq
    apb(1, `IRQSR_ADDR_JITTER, 32'h02);
    apb(1, `IRQSR_ADDR_EVT_STAT, 32'h100);
    apb(1, `IRQSR_ADDR_EVT_EN, 32'h10F);
    period <= 8'h16;
    repeat (50) @(posedge pclk);
    check(irq, 1'b0);
    period <= 8'h17;
    repeat (50) @(posedge pclk);
    check(irq, 1'b1);
    apb(0, `IRQSR_ADDR_EVT_STAT, 0);
    check(rd[8], 1'b1);
    apb(1, `IRQSR_ADDR_EVT_EN, 32'h0F);
    @(posedge pclk);
    check(irq, 1'b0);
    conclude();
  end
endmodule // irqsr_sync_ctrl_test
`default_nettype wire
